// ### hw/todc_pkg.sv
package todc_pkg;
  // System clock and the regulated slow clock that the time counters step on.
  localparam int unsigned SYS_CLK_HZ  = 25_000_000;
  localparam int unsigned SLOW_CLK_HZ = 256;
  // Cycles per slow tick; the fraction is dropped, so the tick runs slightly fast.
  localparam int unsigned DIV_CYCLES  = SYS_CLK_HZ / SLOW_CLK_HZ;
  localparam int unsigned DIV_W       = 17;
  localparam int unsigned PRE_W       = 8;

  // Register byte addresses on the APB.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MS   = 8'h04;
  localparam logic [7:0] ADDR_HOUR = 8'h08;

  // Field positions.
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_H12_BIT = 1;
  localparam int unsigned CTRL_BCD_BIT = 2;
  localparam int unsigned MS_SEC_LSB   = 0;
  localparam int unsigned MS_MIN_LSB   = 8;
  localparam int unsigned HOUR_LSB     = 0;
  localparam int unsigned HOUR_PM_BIT  = 8;

  // Counter limits in binary and BCD form.
  localparam logic [6:0] MS_MAX_BIN  = 7'h3b;
  localparam logic [6:0] MS_MAX_BCD  = 7'h59;
  localparam logic [5:0] H24_MAX_BIN = 6'h17;
  localparam logic [5:0] H24_MAX_BCD = 6'h23;
  localparam logic [5:0] H12_MAX_BIN = 6'h0c;
  localparam logic [5:0] H12_MAX_BCD = 6'h12;
  localparam logic [5:0] H11_BIN     = 6'h0b;
  localparam logic [5:0] H11_BCD     = 6'h11;
  localparam logic [5:0] HOUR_ONE    = 6'h01;
  localparam logic [3:0] DIGIT_NINE  = 4'h9;
  localparam logic [6:0] DEC_TEN     = 7'h0a;

  // Prescaler phases at which the fast rate events fire.
  localparam logic [PRE_W-1:0] PRE_32HZ = 8'h07;
  localparam logic [PRE_W-1:0] PRE_8HZ  = 8'h1f;
  localparam logic [PRE_W-1:0] PRE_4HZ  = 8'h3f;
  localparam logic [PRE_W-1:0] PRE_1HZ  = 8'hff;

  // Event output bit positions.
  localparam int unsigned EV_32HZ = 0;
  localparam int unsigned EV_8HZ  = 1;
  localparam int unsigned EV_4HZ  = 2;
  localparam int unsigned EV_1HZ  = 3;
  localparam int unsigned EV_10S  = 4;
  localparam int unsigned EV_1M   = 5;
  localparam int unsigned EV_10M  = 6;
  localparam int unsigned EV_1H   = 7;
  localparam int unsigned EV_10H  = 8;
  localparam int unsigned EV_HALF = 9;
  localparam int unsigned EV_DAY  = 10;
  localparam int unsigned EV_N    = 11;

  typedef struct packed {
    logic bcd;
    logic h12;
    logic run;
  } todc_ctrl_s;

  typedef struct packed {
    logic       pm;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } todc_time_s;

  typedef struct packed {
    logic t1hz;
    logic t4hz;
    logic t8hz;
    logic t32hz;
  } todc_rate_s;
endpackage

// ### hw/todc_divider.sv
`timescale 1ns/10ps
// Divides the system clock to the 256 Hz slow tick and then to the rate ticks.
module todc_divider #(
  parameter int unsigned DIV_CYCLES_P = todc_pkg::DIV_CYCLES
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               run,
  input  wire logic               restart,
  output todc_pkg::todc_rate_s    rate,
  output logic [todc_pkg::PRE_W-1:0] prescale
);
  import todc_pkg::*;

  logic [DIV_W-1:0] divCnt_reg;   // Cycles inside one slow period.
  logic [PRE_W-1:0] pre_reg;      // Slow periods inside one second.
  logic             slowTick;     // One-cycle 256 Hz enable.
  todc_rate_s       rate_reg;     // Registered rate pulses.
  todc_rate_s       rate_next;

  assign slowTick = run && (divCnt_reg == DIV_W'(DIV_CYCLES_P - 1));

  // Every rate pulse falls on a slow tick, so all of them stay phase aligned.
  assign rate_next.t32hz = slowTick && ((pre_reg & PRE_32HZ) == PRE_32HZ);
  assign rate_next.t8hz  = slowTick && ((pre_reg & PRE_8HZ) == PRE_8HZ);
  assign rate_next.t4hz  = slowTick && ((pre_reg & PRE_4HZ) == PRE_4HZ);
  assign rate_next.t1hz  = slowTick && (pre_reg == PRE_1HZ);

  // The chain freezes while stopped and restarts from phase zero on a start.
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      divCnt_reg <= '0;
      pre_reg    <= '0;
      rate_reg   <= '0;
    end else begin
      rate_reg <= rate_next;
      if (slowTick) begin
        divCnt_reg <= '0;
        pre_reg    <= pre_reg + PRE_W'(1);
      end else if (run) begin
        divCnt_reg <= divCnt_reg + DIV_W'(1);
      end
    end
  end

  assign rate     = rate_reg;
  assign prescale = pre_reg;
endmodule

// ### hw/todc_core.sv
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// - Seconds counter steps once per 1 Hz tick
// - Seconds wrap at sixty, carry to minutes
// - Minutes step only on seconds carry
// - Minutes wrap at sixty, carry to hours
// - BCD mode: tens and units digits
// - Counters readable in selected number form
// - Software write loads any counter
// - Hours counter six bits, 0..23
// - Twelve hour mode counts 1..12
// - BCD hours: two bit tens digit
// - Noon reads twelve, PM flag set
// - Reset leaves counter contents untouched
// - Periodic rate and calendar events
// - Software starts and stops counting
// - PM flag held zero in 24h
// - Format bit one selects twelve hour
// - Run bit one counts, zero halts
// - Tick derived from 256 Hz clock
module todc_core #(
  parameter int unsigned DIV_CYCLES_P = todc_pkg::DIV_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [todc_pkg::EV_N-1:0] eventPulse
);
  import todc_pkg::*;

  // Increment of a seconds or minutes value; the top bit is the wrap carry.
  function automatic logic [7:0] incSixty(input logic [6:0] v, input logic bcd);
    logic [6:0] nxt;
    logic       cry;
    nxt = v + 7'h01;
    cry = 1'b0;
    if (bcd) begin
      if (v == MS_MAX_BCD) begin
        nxt = '0;
        cry = 1'b1;
      end else if (v[3:0] == DIGIT_NINE) begin
        nxt = {v[6:4] + 3'h1, 4'h0};
      end
    end else if (v == MS_MAX_BIN) begin
      nxt = '0;
      cry = 1'b1;
    end
    return {cry, nxt};
  endfunction

  // True when the units digit is nine, so the next step moves the tens digit.
  function automatic logic unitsNine(input logic [6:0] v, input logic bcd);
    return bcd ? (v[3:0] == DIGIT_NINE) : ((v % DEC_TEN) == 7'(DIGIT_NINE));
  endfunction

  // Top hour of the current mode and form.
  function automatic logic [5:0] hourMax(input logic h12, input logic bcd);
    if (h12) begin
      return bcd ? H12_MAX_BCD : H12_MAX_BIN;
    end
    return bcd ? H24_MAX_BCD : H24_MAX_BIN;
  endfunction

  // Hour eleven in the current form.
  function automatic logic [5:0] hourEleven(input logic bcd);
    return bcd ? H11_BCD : H11_BIN;
  endfunction

  // Next hour value for one carry from the minutes counter.
  function automatic logic [5:0] incHour(input logic [5:0] h, input logic h12,
                                         input logic bcd);
    logic [5:0] nxt;
    nxt = h + 6'h01;
    if (h == hourMax(h12, bcd)) begin
      nxt = h12 ? HOUR_ONE : 6'h00;
    end else if (bcd && (h[3:0] == DIGIT_NINE)) begin
      nxt = {h[5:4] + 2'h1, 4'h0};
    end
    return nxt;
  endfunction

  // Architectural state.
  todc_ctrl_s ctrl_reg;        // Run, hour format and BCD selection.
  todc_ctrl_s ctrl_next;
  todc_time_s time_reg;        // Seconds, minutes, hours and PM flag.
  todc_time_s time_next;
  logic [31:0]   prdata_reg;   // Read data, loaded in the setup cycle.
  logic          pready_reg;   // Zero-wait ready.
  logic          pslverr_reg;  // Error for unmapped addresses.
  logic [EV_N-1:0] ev_reg;     // Registered event pulses.
  logic [EV_N-1:0] ev_next;
  // The counters power up unknown, so the history checks below wait until
  // software has loaded them once since the last reset.
  logic          msLoaded_reg;   // Minutes and seconds written since reset.
  logic          hourLoaded_reg; // Hours written since reset.

  // Divider outputs.
  todc_rate_s          rate;
  logic [PRE_W-1:0]    prescale;

  // Bus decode.
  logic apbSetup;
  logic apbWrite;
  logic hitCtrl;
  logic hitMs;
  logic hitHour;
  logic hitAny;
  logic wrCtrl;
  logic wrMs;
  logic wrHour;
  logic startWrite;
  logic [31:0] rdMux;

  // Counting chain.
  logic       tickSec;
  logic [7:0] secInc;
  logic [7:0] minInc;
  logic       carrySec;
  logic       carryMin;
  logic [5:0] hourInc;
  logic [5:0] elevenVal;
  logic       hourIsEleven;
  logic       hourIsMax;
  logic       pmToggle;

  // A transfer takes effect at the access edge; ready is always high there.
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pwrite && pready_reg;
  assign hitCtrl  = (paddr == ADDR_CTRL);
  assign hitMs    = (paddr == ADDR_MS);
  assign hitHour  = (paddr == ADDR_HOUR);
  assign hitAny   = hitCtrl || hitMs || hitHour;
  assign wrCtrl   = apbWrite && hitCtrl;
  assign wrMs     = apbWrite && hitMs;
  assign wrHour   = apbWrite && hitHour;

  // Writing one to the run bit restarts the divider phase.
  assign startWrite = wrCtrl && pwdata[CTRL_RUN_BIT];

  // Read mux shows the counters in whatever form they are kept in.
  assign rdMux = hitCtrl ? {29'h0, ctrl_reg.bcd, ctrl_reg.h12, ctrl_reg.run} :
                 hitMs   ? {17'h0, time_reg.min, 1'b0, time_reg.sec} :
                 hitHour ? {23'h0, time_reg.pm, 2'b00, time_reg.hour} :
                 32'h0;

  // The slow chain starts from the 256 Hz enable, not from any clock pin.
  todc_divider #(
    .DIV_CYCLES_P (DIV_CYCLES_P)
  ) u_divider (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (ctrl_reg.run),
    .restart  (startWrite),
    .rate     (rate),
    .prescale (prescale)
  );

  // Seconds step on the 1 Hz tick only while running; nothing here looks at
  // a sleep signal, so counting goes on through sleep.
  assign tickSec  = rate.t1hz && ctrl_reg.run;
  assign secInc   = incSixty(time_reg.sec, ctrl_reg.bcd);
  assign minInc   = incSixty(time_reg.min, ctrl_reg.bcd);
  assign carrySec = tickSec && secInc[7];
  assign carryMin = carrySec && minInc[7];

  // Hour stepping and the morning/afternoon flag.
  assign hourInc      = incHour(time_reg.hour, ctrl_reg.h12, ctrl_reg.bcd);
  assign elevenVal    = hourEleven(ctrl_reg.bcd);
  assign hourIsEleven = (time_reg.hour == elevenVal);
  assign hourIsMax    = (time_reg.hour == hourMax(ctrl_reg.h12, ctrl_reg.bcd));
  assign pmToggle     = carryMin && ctrl_reg.h12 && hourIsEleven;

  // Control register; a write replaces all three bits at once.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wrCtrl) begin
      ctrl_next.run = pwdata[CTRL_RUN_BIT];
      ctrl_next.h12 = pwdata[CTRL_H12_BIT];
      ctrl_next.bcd = pwdata[CTRL_BCD_BIT];
    end
  end

  // Counter next values. A software write wins over a tick in the same cycle,
  // which is why software should stop the clock before setting it.
  always_comb begin
    time_next = time_reg;
    if (wrMs) begin
      time_next.sec = pwdata[MS_SEC_LSB +: 7];
      time_next.min = pwdata[MS_MIN_LSB +: 7];
    end else begin
      if (tickSec) begin
        time_next.sec = secInc[6:0];
      end
      if (carrySec) begin
        time_next.min = minInc[6:0];
      end
    end
    if (wrHour) begin
      time_next.hour = pwdata[HOUR_LSB +: 6];
      time_next.pm   = pwdata[HOUR_PM_BIT];
    end else if (carryMin) begin
      time_next.hour = hourInc;
      if (pmToggle) begin
        time_next.pm = !time_reg.pm;
      end
    end
    // The flag has no meaning in 24-hour mode and is held low there.
    if (!ctrl_next.h12) begin
      time_next.pm = 1'b0;
    end
  end

  // Periodic events, each a single pulse on the cycle the count moves.
  always_comb begin
    ev_next          = '0;
    ev_next[EV_32HZ] = rate.t32hz;
    ev_next[EV_8HZ]  = rate.t8hz;
    ev_next[EV_4HZ]  = rate.t4hz;
    ev_next[EV_1HZ]  = rate.t1hz;
    ev_next[EV_10S]  = tickSec && unitsNine(time_reg.sec, ctrl_reg.bcd);
    ev_next[EV_1M]   = carrySec;
    ev_next[EV_10M]  = carrySec && unitsNine(time_reg.min, ctrl_reg.bcd);
    ev_next[EV_1H]   = carryMin;
    ev_next[EV_10H]  = carryMin && unitsNine({1'b0, time_reg.hour}, ctrl_reg.bcd);
    ev_next[EV_HALF] = carryMin && (hourIsEleven || (!ctrl_reg.h12 && hourIsMax));
    ev_next[EV_DAY]  = carryMin && (ctrl_reg.h12 ? (hourIsEleven && time_reg.pm)
                                                 : hourIsMax);
  end

  // Control, bus and event flops; these all take the reset.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg    <= '0;
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      ev_reg      <= '0;
      msLoaded_reg   <= 1'b0;
      hourLoaded_reg <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      pready_reg <= 1'b1;
      ev_reg     <= ev_next;
      // Loaded flags only ever rise; reset is the one way back to unknown.
      if (wrMs) begin
        msLoaded_reg <= 1'b1;
      end
      if (wrHour) begin
        hourLoaded_reg <= 1'b1;
      end
      if (apbSetup) begin
        prdata_reg  <= rdMux;
        pslverr_reg <= !hitAny;
      end
    end
  end

  // The time counters carry no reset: a reset pulse must not lose the time.
  always_ff @(posedge clk) begin
    time_reg <= time_next;
  end

  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign eventPulse = ev_reg;

  // Checks on the counting chain and the bus.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A quiet one-second tick with no software write in the way.
  sequence s_quietTick;
    tickSec && !wrMs && !wrHour && !wrCtrl;
  endsequence

  property p_secStep;
    s_quietTick ##0 (!ctrl_reg.bcd && time_reg.sec < MS_MAX_BIN)
      |=> time_reg.sec == $past(time_reg.sec) + 7'h01;
  endproperty
  a_secStep: assert property (p_secStep) else $error("seconds did not step");

  property p_secWrap;
    s_quietTick ##0 (!ctrl_reg.bcd && time_reg.sec == MS_MAX_BIN)
      |=> time_reg.sec == 7'h00 && time_reg.min != $past(time_reg.min);
  endproperty
  a_secWrap: assert property (p_secWrap) else $error("seconds wrap wrong");

  property p_minHold;
    msLoaded_reg && !carrySec && !wrMs |=> $stable(time_reg.min);
  endproperty
  a_minHold: assert property (p_minHold) else $error("minutes moved alone");

  property p_minWrap;
    s_quietTick ##0 (carryMin && !ctrl_reg.bcd)
      |=> time_reg.min == 7'h00 && time_reg.sec == 7'h00;
  endproperty
  a_minWrap: assert property (p_minWrap) else $error("minutes wrap wrong");

  property p_bcdDigit;
    s_quietTick ##0 (ctrl_reg.bcd && time_reg.sec[3:0] == DIGIT_NINE && time_reg.sec != MS_MAX_BCD)
      |=> time_reg.sec == {$past(time_reg.sec[6:4]) + 3'h1, 4'h0};
  endproperty
  a_bcdDigit: assert property (p_bcdDigit) else $error("BCD digit carry wrong");

  property p_hour24Wrap;
    s_quietTick ##0 (carryMin && !ctrl_reg.h12 && hourIsMax) |=> time_reg.hour == 6'h00;
  endproperty
  a_hour24Wrap: assert property (p_hour24Wrap) else $error("24h wrap wrong");

  property p_noon;
    s_quietTick ##0 (carryMin && ctrl_reg.h12 && hourIsEleven)
      |=> time_reg.hour == hourMax(1'b1, ctrl_reg.bcd) && time_reg.pm != $past(time_reg.pm);
  endproperty
  a_noon: assert property (p_noon) else $error("noon step wrong");

  property p_pm24;
    !ctrl_reg.h12 |-> !time_reg.pm;
  endproperty
  a_pm24: assert property (p_pm24) else $error("PM flag set in 24h mode");

  property p_halt;
    msLoaded_reg && hourLoaded_reg && !ctrl_reg.run && !wrMs && !wrHour && !wrCtrl
      |=> $stable(time_reg);
  endproperty
  a_halt: assert property (p_halt) else $error("counters moved while halted");

  property p_loadMs;
    wrMs |=> time_reg.sec == $past(pwdata[MS_SEC_LSB +: 7]);
  endproperty
  a_loadMs: assert property (p_loadMs) else $error("seconds load lost");

  property p_readMs;
    apbSetup && hitMs && !tickSec ##1 (psel && penable && !wrMs)
      |-> prdata == {17'h0, time_reg.min, 1'b0, time_reg.sec};
  endproperty
  a_readMs: assert property (p_readMs) else $error("read data mismatch");
endmodule

// ### bench/todc_core_tb.sv
`timescale 1ns/10ps
// Self-checking bench for the time-of-day counter core, driven over APB.
module todc_core_tb;
  import todc_pkg::*;

  // A short divider keeps one second at 1024 system cycles.
  localparam int unsigned DIV_P = 4;

  logic                  clk = 1'b0;        // System clock, 25 MHz.
  logic                  rst_n = 1'b0;      // Synchronous reset, active low.
  logic                  psel = 1'b0;       // APB select.
  logic                  penable = 1'b0;    // APB enable.
  logic                  pwrite = 1'b0;     // APB direction.
  logic [7:0]            paddr = 8'h00;     // APB byte address.
  logic [31:0]           pwdata = 32'h0;    // APB write data.
  logic [31:0]           prdata;            // APB read data.
  logic                  pready;            // APB ready.
  logic                  pslverr;           // APB error.
  logic [EV_N-1:0]       eventPulse;        // Event pulses.
  logic [EV_N-1:0]       evSeen;            // Events gathered during the last watch.
  logic [31:0]           rd;                // Read data of the last transfer.
  logic                  re;                // Error flag of the last transfer.
  int                    err_total = 0;     // Mismatches seen.
  int                    compares = 0;      // Comparisons made.

  todc_core #(.DIV_CYCLES_P(DIV_P)) u_dut (
    .clk        (clk),
    .rst_n      (rst_n),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .eventPulse (eventPulse)
  );

  // The clock toggles every half period of 20 ns.
  always #20 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one and counts the result.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s: saw %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        break;
      end
    end
    rd = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      err_total++;
      $display("[FAIL] %0t bus transfer never completed", $time);
      finish_test();
    end
  endtask

  // Gathers events over up to n cycles; with stop1 it ends at the first 1 Hz tick.
  task automatic watch(input int n, input bit stop1);
    int i;
    evSeen = '0;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      #1;
      evSeen |= eventPulse;
      if (stop1 && eventPulse[EV_1HZ] === 1'b1) begin
        break;
      end
    end
    if (stop1 && i == n) begin
      err_total++;
      $display("[FAIL] %0t no one second tick arrived", $time);
      finish_test();
    end
  endtask

  // Register word builders; the field positions come from the package.
  function automatic logic [31:0] ctl(input logic run, input logic h12, input logic bcd);
    return (32'(run) << CTRL_RUN_BIT) | (32'(h12) << CTRL_H12_BIT) | (32'(bcd) << CTRL_BCD_BIT);
  endfunction
  function automatic logic [31:0] msw(input logic [6:0] m, input logic [6:0] s);
    return (32'(m) << MS_MIN_LSB) | (32'(s) << MS_SEC_LSB);
  endfunction
  function automatic logic [31:0] hrw(input logic pm, input logic [5:0] h);
    return (32'(pm) << HOUR_PM_BIT) | (32'(h) << HOUR_LSB);
  endfunction
  function automatic logic [EV_N-1:0] ev(input int b);
    return EV_N'(1) << b;
  endfunction

  // Loads a time while stopped, runs for one tick, stops and compares time and events.
  // Loading while stopped follows the safe procedure; a write during a tick is not covered.
  task automatic roll(input logic [31:0] c, input logic [31:0] ms0, input logic [31:0] hr0,
                      input logic [31:0] msExp, input logic [31:0] hrExp,
                      input logic [EV_N-1:0] mask);
    apb(1'b1, ADDR_CTRL, c);
    apb(1'b1, ADDR_MS, ms0);
    apb(1'b1, ADDR_HOUR, hr0);
    apb(1'b1, ADDR_CTRL, c | ctl(1'b1, 1'b0, 1'b0));
    watch(1200, 1'b1);
    apb(1'b1, ADDR_CTRL, c);
    apb(1'b0, ADDR_MS, 32'h0);
    check(rd, msExp, "minutes and seconds after tick");
    apb(1'b0, ADDR_HOUR, 32'h0);
    check(rd, hrExp, "hours after tick");
    check(32'(evSeen & mask), 32'(mask), "events on tick");
  endtask

  // Counter contents survive a reset while stopped, control clears, bad address errs.
  task automatic t_reset();
    apb(1'b1, ADDR_MS, msw(7'd1, 7'd35));
    apb(1'b1, ADDR_HOUR, hrw(1'b0, 6'd9));
    apb(1'b1, ADDR_CTRL, ctl(1'b0, 1'b0, 1'b1));
    check(32'(re), 32'h0, "mapped write flagged");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, ADDR_MS, 32'h0);
    check(rd, msw(7'd1, 7'd35), "minutes and seconds after reset");
    apb(1'b0, ADDR_HOUR, 32'h0);
    check(rd, hrw(1'b0, 6'd9), "hours after reset");
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0, "control after reset");
    apb(1'b0, 8'h0c, 32'h0);
    check({rd[30:0], re}, 32'h1, "unmapped read");
    $display("test reset done");
  endtask

  // In 24-hour mode the PM flag is held at zero even when written as one.
  task automatic t_pm24();
    apb(1'b1, ADDR_HOUR, hrw(1'b1, 6'd5));
    apb(1'b0, ADDR_HOUR, 32'h0);
    check(rd, hrw(1'b0, 6'd5), "pm flag in 24 hour mode");
    $display("test pm24 done");
  endtask

  // A plain tick moves only the seconds; minutes wait for a carry.
  task automatic t_sec();
    roll(ctl(1'b0, 1'b0, 1'b0), msw(7'd7, 7'd5), hrw(1'b0, 6'd3),
         msw(7'd7, 7'd6), hrw(1'b0, 6'd3), ev(EV_1HZ) | ev(EV_32HZ) | ev(EV_4HZ));
    check(32'(evSeen[EV_1M]), 32'h0, "minute event without carry");
    $display("test seconds done");
  endtask

  // Binary 24-hour wrap at the end of the day ripples through every counter.
  task automatic t_day24();
    roll(ctl(1'b0, 1'b0, 1'b0), msw(7'h3b, 7'h3b), hrw(1'b0, 6'h17), msw(7'h0, 7'h0),
         hrw(1'b0, 6'h0), ev(EV_10S) | ev(EV_1M) | ev(EV_10M) | ev(EV_1H) | ev(EV_HALF)
         | ev(EV_DAY) | ev(EV_8HZ));
    $display("test day24 done");
  endtask

  // BCD digits carry from units to tens in seconds and hours; minutes only wrap from 59.
  task automatic t_bcd();
    roll(ctl(1'b0, 1'b0, 1'b1), msw(7'h59, 7'h59), hrw(1'b0, 6'h09),
         msw(7'h00, 7'h00), hrw(1'b0, 6'h10), ev(EV_10S) | ev(EV_1M) | ev(EV_10M)
         | ev(EV_1H) | ev(EV_10H));
    roll(ctl(1'b0, 1'b0, 1'b1), msw(7'h12, 7'h19), hrw(1'b0, 6'h21),
         msw(7'h12, 7'h20), hrw(1'b0, 6'h21), ev(EV_10S));
    check(32'(evSeen[EV_1M]), 32'h0, "minute event on units carry");
    $display("test bcd done");
  endtask

  // Twelve-hour mode: eleven to noon sets PM, noon to one keeps it, BCD midnight clears it.
  task automatic t_h12();
    roll(ctl(1'b0, 1'b1, 1'b0), msw(7'h3b, 7'h3b), hrw(1'b0, 6'h0b),
         msw(7'h0, 7'h0), hrw(1'b1, 6'h0c), ev(EV_HALF));
    roll(ctl(1'b0, 1'b1, 1'b0), msw(7'h3b, 7'h3b), hrw(1'b1, 6'h0c),
         msw(7'h0, 7'h0), hrw(1'b1, 6'h01), ev(EV_1H));
    roll(ctl(1'b0, 1'b1, 1'b1), msw(7'h59, 7'h59), hrw(1'b1, 6'h11),
         msw(7'h0, 7'h0), hrw(1'b0, 6'h12), ev(EV_HALF) | ev(EV_DAY));
    $display("test h12 done");
  endtask

  // Clearing the run bit freezes the counters and silences every event.
  task automatic t_stop();
    roll(ctl(1'b0, 1'b0, 1'b0), msw(7'd2, 7'd3), hrw(1'b0, 6'd1),
         msw(7'd2, 7'd4), hrw(1'b0, 6'd1), ev(EV_1HZ));
    watch(1200, 1'b0);
    check(32'(evSeen), 32'h0, "events while stopped");
    apb(1'b0, ADDR_MS, 32'h0);
    check(rd, msw(7'd2, 7'd4), "time while stopped");
    $display("test stop done");
  endtask

  // Main sequence: hold reset for 16 cycles, then run each scenario in turn.
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_pm24();
    t_sec();
    t_day24();
    t_bcd();
    t_h12();
    t_stop();
    finish_test();
  end
endmodule
